/* hw/status_pkg.sv */
// Constants for the core status flags register.
// Assumes an 8-bit data path and a single core clock.
package status_pkg;
    localparam logic [7:0] STATUS_ADDR_BANK0 = 8'h03;
    localparam logic [7:0] STATUS_ADDR_BANK1 = 8'h83;
    localparam int         BIT_CARRY         = 0;
    localparam int         BIT_DIGIT_CARRY   = 1;
    localparam int         BIT_ZERO          = 2;
    localparam int         BIT_POWERDOWN     = 3;
    localparam int         BIT_TIMEOUT       = 4;
    localparam int         BIT_BANK_LOW      = 5;
    localparam int         BIT_BANK_HIGH     = 6;
    localparam int         BIT_INDIRECT      = 7;
    localparam logic [2:0] RESET_BANK_BITS   = 3'h0;
    localparam logic [1:0] RESET_INDICATORS  = 2'h3;
    localparam logic [2:0] RESET_ALU_FLAGS   = 3'h0;
    localparam logic [6:0] BANK_OFFSET_MASK  = 7'h7f;

    typedef enum logic [3:0] {
        ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COMP,
        ALU_INC, ALU_DEC, ALU_RLF, ALU_RRF, ALU_SWAP, ALU_CLEAR, ALU_BITOP
    } alu_op_t;
endpackage : status_pkg

/* hw/flag_if.sv */
// Bundle between the ALU flag unit and the status register.
// Assumes both ends sit on the core clock.
`timescale 1ns/1ps
interface flag_if;
    logic [7:0] result;
    logic       zero;
    logic       digit_carry;
    logic       carry;
    logic       upd_z;
    logic       upd_dc;
    logic       upd_c;
    modport alu (output result, zero, digit_carry, carry, upd_z, upd_dc, upd_c);
    modport reg_side (input result, zero, digit_carry, carry, upd_z, upd_dc, upd_c);
endinterface : flag_if

/* hw/alu_flags.sv */
// ALU result and flag generation for the status register.
// Assumes operands are stable for the cycle the op is presented.
`timescale 1ns/1ps
module alu_flags (
    input  wire status_pkg::alu_op_t op_i,
    input  wire logic [7:0]          a_i,
    input  wire logic [7:0]          b_i,
    input  wire logic                carry_in_i,
    flag_if.alu                      f
);
    logic [8:0] sum;
    logic [4:0] nib;
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        f.result = a_i;
        f.carry = carry_in_i;
        f.digit_carry = 1'b0;
        f.upd_z = 1'b0;
        f.upd_dc = 1'b0;
        f.upd_c = 1'b0;
        unique case (op_i)
            status_pkg::ALU_ADD: begin
                sum = {1'b0, a_i} + {1'b0, b_i};
                nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
                f.result = sum[7:0];
                f.carry = sum[8];
                f.digit_carry = nib[4];
                {f.upd_z, f.upd_dc, f.upd_c} = 3'h7;
            end
            status_pkg::ALU_SUB: begin
                sum = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
                nib = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
                f.result = sum[7:0];
                f.carry = sum[8];
                f.digit_carry = nib[4];
                {f.upd_z, f.upd_dc, f.upd_c} = 3'h7;
            end
            status_pkg::ALU_AND: begin f.result = a_i & b_i; f.upd_z = 1'b1; end
            status_pkg::ALU_OR:  begin f.result = a_i | b_i; f.upd_z = 1'b1; end
            status_pkg::ALU_XOR: begin f.result = a_i ^ b_i; f.upd_z = 1'b1; end
            status_pkg::ALU_COMP: begin f.result = ~a_i; f.upd_z = 1'b1; end
            status_pkg::ALU_INC: begin f.result = a_i + 8'h01; f.upd_z = 1'b1; end
            status_pkg::ALU_DEC: begin f.result = a_i - 8'h01; f.upd_z = 1'b1; end
            status_pkg::ALU_PASS: f.upd_z = 1'b1;
            status_pkg::ALU_RLF: begin
                f.result = {a_i[6:0], carry_in_i};
                f.carry = a_i[7];
                f.upd_c = 1'b1;
            end
            status_pkg::ALU_RRF: begin
                f.result = {carry_in_i, a_i[7:1]};
                f.carry = a_i[0];
                f.upd_c = 1'b1;
            end
            status_pkg::ALU_SWAP: f.result = {a_i[3:0], a_i[7:4]};
            status_pkg::ALU_CLEAR: begin f.result = 8'h00; f.upd_z = 1'b1; end
            status_pkg::ALU_BITOP: f.result = a_i;
            default: f.result = a_i;
        endcase
        f.zero = (f.result == 8'h00);
    end
endmodule : alu_flags

/* hw/cpu_status.sv */
// Status register of an 8-bit core: ALU flags, reset indicators, bank bits.
// Assumes the execute stage presents one instruction per enabled cycle.
`timescale 1ns/1ps
// Behaviour
// - Status register accepts any instruction write
// - Flag-setting instructions override written flag bits
// - Indicator bits ignore instruction writes
// - Clear gives 000u u1uu pattern
// - Bank bits select 128-byte bank
// - Add carry equals carry out
// - Subtract carries are inverted borrows
// - Rotate loads carry from shifted bit
// - Register answers at both bank addresses
module cpu_status (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic                exec_en_i,
    input  wire status_pkg::alu_op_t op_i,
    input  wire logic [7:0]          operand_a_i,
    input  wire logic [7:0]          operand_b_i,
    input  wire logic                write_en_i,
    input  wire logic [7:0]          write_addr_i,
    input  wire logic [7:0]          read_addr_i,
    input  wire logic [6:0]          direct_offset_i,
    input  wire logic                wdt_timeout_i,
    input  wire logic                sleep_entry_i,
    input  wire logic                clrwdt_i,
    output logic [7:0]               result_o,
    output logic [7:0]               status_o,
    output logic                     status_read_hit_o,
    output logic [8:0]               direct_addr_o,
    output logic                     carry_o
);
    typedef struct packed {
        logic       indirect_bank_bit;
        logic       bank_select_high;
        logic       bank_select_low;
        logic       timeout_indicator;
        logic       powerdown_indicator;
        logic       zero_flag;
        logic       digit_carry_flag;
        logic       carry_flag;
        logic [7:0] result;
    } state_t;

    state_t   st;
    state_t   next_st;
    logic     write_hit;
    logic [7:0] cur;

    flag_if f ();

    alu_flags alu_flags_inst (
        .op_i       (op_i),
        .a_i        (operand_a_i),
        .b_i        (operand_b_i),
        .carry_in_i (st.carry_flag),
        .f          (f)
    );

    assign cur = {st.indirect_bank_bit, st.bank_select_high, st.bank_select_low,
                  st.timeout_indicator, st.powerdown_indicator,
                  st.zero_flag, st.digit_carry_flag, st.carry_flag};

    assign write_hit = write_en_i && ((write_addr_i == status_pkg::STATUS_ADDR_BANK0)
                                   || (write_addr_i == status_pkg::STATUS_ADDR_BANK1));
    assign status_read_hit_o = (read_addr_i == status_pkg::STATUS_ADDR_BANK0)
                            || (read_addr_i == status_pkg::STATUS_ADDR_BANK1);

    always_comb begin
        next_st = st;
        if (exec_en_i) begin
            next_st.result = f.result;
            if (write_hit) begin
                next_st.indirect_bank_bit = f.result[status_pkg::BIT_INDIRECT];
                next_st.bank_select_high  = f.result[status_pkg::BIT_BANK_HIGH];
                next_st.bank_select_low   = f.result[status_pkg::BIT_BANK_LOW];
                // any flag-affecting op blocks all three flag writes
                if (!(f.upd_z || f.upd_dc || f.upd_c)) begin
                    next_st.zero_flag        = f.result[status_pkg::BIT_ZERO];
                    next_st.digit_carry_flag = f.result[status_pkg::BIT_DIGIT_CARRY];
                    next_st.carry_flag       = f.result[status_pkg::BIT_CARRY];
                end
            end
            // ALU flags win over data write
            if (f.upd_z) begin
                next_st.zero_flag = f.zero;
            end
            if (f.upd_dc) begin
                next_st.digit_carry_flag = f.digit_carry;
            end
            if (f.upd_c) begin
                next_st.carry_flag = f.carry;
            end
        end
        // indicators driven by reset and sleep logic
        if (clrwdt_i) begin
            next_st.timeout_indicator   = 1'b1;
            next_st.powerdown_indicator = 1'b1;
        end
        if (sleep_entry_i) begin
            next_st.timeout_indicator   = 1'b1;
            next_st.powerdown_indicator = 1'b0;
        end
        if (wdt_timeout_i) begin
            next_st.timeout_indicator = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {st.indirect_bank_bit, st.bank_select_high, st.bank_select_low}
                <= status_pkg::RESET_BANK_BITS;
            {st.timeout_indicator, st.powerdown_indicator} <= status_pkg::RESET_INDICATORS;
            {st.zero_flag, st.digit_carry_flag, st.carry_flag} <= status_pkg::RESET_ALU_FLAGS;
            st.result <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign result_o = st.result;
    assign status_o = cur;
    assign carry_o  = st.carry_flag;
    // two bank bits pick one of four 128-byte banks
    assign direct_addr_o = {st.bank_select_high, st.bank_select_low,
                            direct_offset_i & status_pkg::BANK_OFFSET_MASK};
endmodule : cpu_status

/* bench/cpu_status_props.sv */
// Port checker for the status register.
// Assumes it is bound to cpu_status; one clock, async reset.
`timescale 1ns/1ps
module cpu_status_props (
    input wire logic                clk_i,
    input wire logic                sys_rst_i,
    input wire logic                exec_en_i,
    input wire status_pkg::alu_op_t op_i,
    input wire logic [7:0]          operand_a_i,
    input wire logic [7:0]          operand_b_i,
    input wire logic                write_en_i,
    input wire logic [7:0]          write_addr_i,
    input wire logic [7:0]          read_addr_i,
    input wire logic [6:0]          direct_offset_i,
    input wire logic                wdt_timeout_i,
    input wire logic                sleep_entry_i,
    input wire logic                clrwdt_i,
    input wire logic [7:0]          status_o,
    input wire logic                status_read_hit_o,
    input wire logic [8:0]          direct_addr_o,
    input wire logic                carry_o
);
    logic [8:0] add_sum;
    logic       sub_nb;
    logic       hit_w;
    logic       quiet;
    assign add_sum = {1'b0, operand_a_i} + {1'b0, operand_b_i};
    assign sub_nb  = operand_a_i >= operand_b_i;
    assign hit_w   = exec_en_i && write_en_i && (write_addr_i == 8'h03 || write_addr_i == 8'h83);
    // Indicator pulses may legally move bits 4:3 in the same cycle
    assign quiet   = !wdt_timeout_i && !sleep_entry_i && !clrwdt_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_value: assert property (
        $fell(sys_rst_i) |-> status_o[7:3] == 5'h03) else $error("reset value wrong");
    a_read_hit: assert property (
        status_read_hit_o == (read_addr_i == 8'h03 || read_addr_i == 8'h83))
        else $error("status read decode wrong");
    a_bank_map: assert property (
        direct_addr_o == {status_o[6:5], direct_offset_i}) else $error("direct address wrong");
    a_add_carry: assert property (
        exec_en_i && op_i == status_pkg::ALU_ADD |=> carry_o == $past(add_sum[8]))
        else $error("add carry wrong");
    a_sub_borrow: assert property (
        exec_en_i && op_i == status_pkg::ALU_SUB |=> carry_o == $past(sub_nb))
        else $error("subtract carry wrong");
    a_rotate_carry: assert property (
        exec_en_i && op_i == status_pkg::ALU_RLF |=> carry_o == $past(operand_a_i[7]))
        else $error("rotate carry wrong");
    a_indic_ro: assert property (
        hit_w && quiet |=> $stable(status_o[4:3])) else $error("indicator bits written");
    a_clear_mask: assert property (
        hit_w && quiet && op_i == status_pkg::ALU_CLEAR |=> status_o[7:5] == 3'h0
        && status_o[2] && $stable(status_o[1:0])) else $error("clear pattern wrong");
endmodule : cpu_status_props
bind cpu_status cpu_status_props cpu_status_props_inst (.clk_i, .sys_rst_i, .exec_en_i, .op_i,
    .operand_a_i, .operand_b_i, .write_en_i, .write_addr_i, .read_addr_i, .direct_offset_i,
    .wdt_timeout_i, .sleep_entry_i, .clrwdt_i, .status_o, .status_read_hit_o, .direct_addr_o,
    .carry_o);

/* bench/exec_model.sv */
// Execution-unit model: one instruction per call, then idle.
// Assumes the core clock; drives on the falling edge.
`timescale 1ns/1ps
module exec_model (
    input  wire logic           clk_i,
    output status_pkg::alu_op_t op_o,
    output logic [7:0]          a_o,
    output logic [7:0]          b_o,
    output logic                exec_en_o,
    output logic                write_en_o,
    output logic [7:0]          addr_o
);
    initial begin
        {exec_en_o, write_en_o, a_o, b_o, addr_o} = '0;
        op_o = status_pkg::ALU_PASS;
    end
    task automatic issue(input status_pkg::alu_op_t op, input logic [7:0] a, b, ad, input logic w);
        @(negedge clk_i);
        op_o = op;
        a_o = (w && op == status_pkg::ALU_BITOP) ? (a & 8'h3f) : a;
        {b_o, addr_o, write_en_o, exec_en_o} = {b, ad, w, 1'b1};
        @(negedge clk_i);
        {write_en_o, exec_en_o} = 2'h0;
    endtask : issue
endmodule : exec_model

/* bench/tb_cpu_status.sv */
// Self-checking bench for the status register.
// Assumes package, interface and design files are compiled first.
`timescale 1ns/1ps
module tb_cpu_status;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, wdt = 1'b0, slp = 1'b0, clw = 1'b0;
    logic [7:0] raddr = 8'h00, waddr, a, b, res, st;
    logic [6:0] doff = 7'h55;
    logic [8:0] daddr;
    logic hit, cy, en, we;
    status_pkg::alu_op_t op;
    int errors = 0, tests_run = 0;
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    exec_model exec_model_inst (.clk_i, .op_o(op), .a_o(a), .b_o(b), .exec_en_o(en),
        .write_en_o(we), .addr_o(waddr));
    cpu_status cpu_status_inst (.clk_i, .sys_rst_i, .exec_en_i(en), .op_i(op), .operand_a_i(a),
        .operand_b_i(b), .write_en_i(we), .write_addr_i(waddr), .read_addr_i(raddr),
        .direct_offset_i(doff), .wdt_timeout_i(wdt), .sleep_entry_i(slp), .clrwdt_i(clw),
        .result_o(res), .status_o(st), .status_read_hit_o(hit), .direct_addr_o(daddr),
        .carry_o(cy));
    task automatic check(input string n, input logic [8:0] s, e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic test_done();
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic pulse(ref logic p, input logic [1:0] e);
        @(negedge clk_i);
        p = 1'b1;
        @(negedge clk_i);
        p = 1'b0;
        check("indicators", st[4:3], e);
    endtask : pulse
    task automatic t_write();
        exec_model_inst.issue(status_pkg::ALU_BITOP, 8'h27, 8'h00, 8'h03, 1'b1);
        check("status", st, 8'h3f);
        check("bank address", daddr, 9'h0d5);
        exec_model_inst.issue(status_pkg::ALU_BITOP, 8'h00, 8'h00, 8'h83, 1'b1);
        check("status", st, 8'h18);
        check("bank address", daddr, 9'h055);
        exec_model_inst.issue(status_pkg::ALU_BITOP, 8'h23, 8'h00, 8'h03, 1'b1);
        exec_model_inst.issue(status_pkg::ALU_CLEAR, 8'h00, 8'h00, 8'h83, 1'b1);
        check("cleared status", st, 8'h1f);
    endtask : t_write
    task automatic t_arith();
        logic [7:0] av [5] = '{8'hff, 8'h0f, 8'h05, 8'h03, 8'h07};
        logic [7:0] bv [5] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h07};
        logic [8:0] s;
        logic [2:0] f;
        for (int i = 0; i < 5; i++) begin
            exec_model_inst.issue(i < 2 ? status_pkg::ALU_ADD : status_pkg::ALU_SUB,
                av[i], bv[i], 8'h03, i == 0);
            s = (i < 2) ? av[i] + bv[i] : av[i] - bv[i];
            f = {s[7:0] == 8'h00, av[i][3:0] + bv[i][3:0] > 5'h0f, s[8]};
            if (i >= 2) f[1:0] = {av[i][3:0] >= bv[i][3:0], av[i] >= bv[i]};
            check("result", res, s[7:0]);
            check("flags", st[2:0], f);
        end
        exec_model_inst.issue(status_pkg::ALU_RLF, 8'h80, 8'h00, 8'h20, 1'b0);
        check("rotate left carry", cy, 1'b1);
        exec_model_inst.issue(status_pkg::ALU_RRF, 8'hfe, 8'h00, 8'h20, 1'b0);
        check("rotate right carry", cy, 1'b0);
    endtask : t_arith
    task automatic t_read_hit();
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_i) raddr = (i == 2) ? 8'h43 : {i[0], 7'h03};
            #1 check("read hit", hit, i < 2);
        end
    endtask : t_read_hit
    task automatic t_reset();
        exec_model_inst.issue(status_pkg::ALU_BITOP, 8'h20, 8'h00, 8'h03, 1'b1);
        pulse(wdt, 2'h1);
        @(negedge clk_i) sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("reset status", st[7:3], 5'h03);
        sys_rst_i = 1'b0;
        exec_model_inst.issue(status_pkg::ALU_ADD, 8'h01, 8'h02, 8'h20, 1'b0);
        check("result", res, 8'h03);
    endtask : t_reset
    initial begin
        repeat (2000) @(posedge clk_i);
        errors++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        check("reset status", st[7:3], 5'h03);
        @(negedge clk_i) sys_rst_i = 1'b0;
        t_write();
        t_arith();
        t_read_hit();
        pulse(slp, 2'h2);
        pulse(wdt, 2'h0);
        pulse(clw, 2'h3);
        t_reset();
        test_done();
    end
endmodule : tb_cpu_status
